/* rtl/dacdp_defs.svh */
// Register indices, field positions and reset values of the playback path configuration
`ifndef DACDP_DEFS_SVH
`define DACDP_DEFS_SVH

`define DACDP_IDX_RSVD_A 8'h35
`define DACDP_IDX_DIN 8'h36
`define DACDP_IDX_RSVD_B_LO 8'h37
`define DACDP_IDX_RSVD_B_HI 8'h3b
`define DACDP_IDX_BLK 8'h3c
`define DACDP_IDX_RSVD_C_LO 8'h3d
`define DACDP_IDX_RSVD_C_HI 8'h3e
`define DACDP_IDX_SETUP 8'h3f
`define DACDP_IDX_VOL 8'h40

`define DACDP_DIN_MODE_LSB 1
`define DACDP_SETUP_LPWR 7
`define DACDP_SETUP_RPWR 6
`define DACDP_SETUP_LSRC_LSB 4
`define DACDP_SETUP_RSRC_LSB 2
`define DACDP_SETUP_STEP_LSB 0
`define DACDP_VOL_LMUTE 3
`define DACDP_VOL_RMUTE 2
`define DACDP_VOL_CPL_LSB 0

`define DACDP_RST_DIN_MODE 2'h1
`define DACDP_RST_BLK 5'h01
`define DACDP_BLK_FIRST 5'h01
`define DACDP_BLK_LAST 5'h19
`define DACDP_RST_SRC 2'h1
`define DACDP_RST_STEP 2'h0
`define DACDP_RST_MUTE 1'b1
`define DACDP_RST_CPL 2'h0

`define DACDP_RESP_OKAY 2'h0
`define DACDP_RESP_DECERR 2'h3

`endif

/* rtl/dacdp_pkg.sv */
// Types of the playback path configuration block
package dacdp_pkg;

    typedef enum logic [1:0] {DACDP_PIN_OFF, DACDP_PIN_SERIAL, DACDP_PIN_GPI, DACDP_PIN_RSVD}
        dacdp_pin_mode_t;

    typedef enum logic [1:0] {DACDP_SRC_OFF, DACDP_SRC_OWN, DACDP_SRC_OTHER, DACDP_SRC_AVG}
        dacdp_src_t;

    typedef enum logic [1:0] {DACDP_STEP_ONE, DACDP_STEP_TWO, DACDP_STEP_NONE, DACDP_STEP_RSVD}
        dacdp_step_t;

    typedef enum logic [1:0] {DACDP_CPL_INDEP, DACDP_CPL_L_FROM_R, DACDP_CPL_R_FROM_L,
        DACDP_CPL_INDEP2} dacdp_cpl_t;

    typedef struct packed {
        dacdp_pin_mode_t din_mode;
        logic [4:0] block_sel;
        logic left_power;
        logic right_power;
        dacdp_src_t left_src;
        dacdp_src_t right_src;
        dacdp_step_t soft_step;
        logic left_mute;
        logic right_mute;
        dacdp_cpl_t coupling;
    } dacdp_cfg_t;

endpackage : dacdp_pkg

/* rtl/dacdp_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dacdp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,              // Clock
    input wire logic nrst_i,             // Sync reset, active low
    input wire logic [WIDTH-1:0] d_i,    // Asynchronous input
    output logic [WIDTH-1:0] q_o         // Synchronised output
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule : dacdp_sync
`default_nettype wire

/* rtl/dacdp_mix.sv */
// One converter channel: source routing, averaging, power and mute gating
`timescale 1ns/1ps
`default_nettype none
module dacdp_mix
    import dacdp_pkg::*;
#(
    parameter int SAMPLE_W = 24
) (
    input wire logic clk_i,                          // Clock
    input wire logic nrst_i,                         // Sync reset, active low
    input wire logic valid_i,                        // Sample pair valid
    input wire logic signed [SAMPLE_W-1:0] own_i,    // Own-side sample
    input wire logic signed [SAMPLE_W-1:0] other_i,  // Other-side sample
    input wire dacdp_src_t src_i,                    // Source select
    input wire logic pass_i,                         // Powered and not muted
    output logic valid_o,                            // Output valid
    output logic signed [SAMPLE_W-1:0] sample_o      // Routed sample
);
    logic signed [SAMPLE_W:0] sum;
    logic signed [SAMPLE_W-1:0] pick;
    logic signed [SAMPLE_W-1:0] sample_d;
    logic signed [SAMPLE_W-1:0] sample_q;
    logic valid_q;

    always_comb
    begin
        sum = {own_i[SAMPLE_W-1], own_i} + {other_i[SAMPLE_W-1], other_i};
        case (src_i)
            DACDP_SRC_OWN: pick = own_i;
            DACDP_SRC_OTHER: pick = other_i;
            DACDP_SRC_AVG: pick = sum[SAMPLE_W:1];
            default: pick = '0;
        endcase
        sample_d = sample_q;
        if (valid_i)
            sample_d = pass_i ? pick : '0;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            sample_q <= '0;
            valid_q <= 1'b0;
        end
        else
        begin
            sample_q <= sample_d;
            valid_q <= valid_i;
        end
    end

    assign sample_o = sample_q;
    assign valid_o = valid_q;

    property p_avg;
        @(posedge clk_i) disable iff (!nrst_i)
        valid_i && pass_i && src_i == DACDP_SRC_AVG |=> sample_o == $past(sum[SAMPLE_W:1]);
    endproperty
    a_avg: assert property (p_avg) else $error("average sample wrong");

    property p_route;
        @(posedge clk_i) disable iff (!nrst_i)
        valid_i && (!pass_i || src_i == DACDP_SRC_OFF) |=> sample_o == '0;
    endproperty
    a_route: assert property (p_route) else $error("gated channel not silent");
endmodule : dacdp_mix
`default_nettype wire

/* rtl/dacdp_regs.sv */
// Playback path configuration registers with AXI4-Lite slave and channel routing
`timescale 1ns/1ps
`default_nettype none
`include "dacdp_defs.svh"

// Overview of operation
// - Data pin mode 00 off, 01 serial/clock input, 10 general input, 11 reserved; resets 01; D0 shows the synchronised pin, 0 in mode 00.
// - Block selector picks block 1 to 25 by codes 1 to 25, resets to 1; other codes are not taken.
// - Setup bit 7 powers the left channel up when set, reset powered down.
// - Setup bit 6 powers the right channel up when set, reset powered down.
// - Left source 00 none, 01 left, 10 right, 11 average, reset 01.
// - Right source 00 none, 01 right, 10 left, 11 average, reset 01.
// - Soft-step 00 one step per sample, 01 per two samples, 10 immediate; 11 is never stored.
// - Volume bit 3 mutes the left channel, reset muted.
// - Volume bit 2 mutes the right channel, reset muted.
// - Coupling 00/11 independent, 01 left takes right gain, 10 right takes left gain.
// - While the compressor is on, volumes stay independent whatever the coupling field.
module dacdp_regs
    import dacdp_pkg::*;
#(
    parameter int ADDR_W = 10,
    parameter int SAMPLE_W = 24,
    parameter int VOL_W = 8
) (
    input wire logic clk_i,                              // Clock, 20 MHz
    input wire logic nrst_i,                             // Sync reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,        // Write address
    input wire logic s_axi_awvalid_i,                    // Write address valid
    output logic s_axi_awready_o,                        // Write address ready
    input wire logic [31:0] s_axi_wdata_i,               // Write data
    input wire logic [3:0] s_axi_wstrb_i,                // Write strobes
    input wire logic s_axi_wvalid_i,                     // Write data valid
    output logic s_axi_wready_o,                         // Write data ready
    output logic [1:0] s_axi_bresp_o,                    // Write response
    output logic s_axi_bvalid_o,                         // Write response valid
    input wire logic s_axi_bready_i,                     // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,        // Read address
    input wire logic s_axi_arvalid_i,                    // Read address valid
    output logic s_axi_arready_o,                        // Read address ready
    output logic [31:0] s_axi_rdata_o,                   // Read data
    output logic [1:0] s_axi_rresp_o,                    // Read response
    output logic s_axi_rvalid_o,                         // Read data valid
    input wire logic s_axi_rready_i,                     // Read data ready
    input wire logic din_pin_i,                          // Data input pin, asynchronous
    output logic din_serial_en_o,                        // Pin feeds serial port / clocks
    output logic din_gpi_o,                              // Pin level as general input
    input wire logic drc_enable_i,                       // Compressor active
    input wire logic [VOL_W-1:0] left_vol_i,             // Programmed left gain
    input wire logic [VOL_W-1:0] right_vol_i,            // Programmed right gain
    output logic [VOL_W-1:0] left_vol_o,                 // Effective left gain
    output logic [VOL_W-1:0] right_vol_o,                // Effective right gain
    output dacdp_cfg_t cfg_o,                            // Configuration fields
    input wire logic sample_valid_i,                     // Input sample pair valid
    input wire logic signed [SAMPLE_W-1:0] left_i,       // Left input sample
    input wire logic signed [SAMPLE_W-1:0] right_i,      // Right input sample
    output logic left_valid_o,                           // Left output valid
    output logic signed [SAMPLE_W-1:0] left_o,           // Left channel sample
    output logic right_valid_o,                          // Right output valid
    output logic signed [SAMPLE_W-1:0] right_o           // Right channel sample
);
    localparam int IW = ADDR_W - 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin input

    logic din_sync;

    dacdp_sync #(.WIDTH(1)) u_din_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i(din_pin_i),
        .q_o(din_sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read decode: {error, byte}

    dacdp_cfg_t cfg_q;
    dacdp_cfg_t cfg_d;
    logic din_level;

    assign din_level = (cfg_q.din_mode != DACDP_PIN_OFF) ? din_sync : 1'b0;

    function automatic logic [8:0] rd_word(input logic [IW-1:0] idx);
        logic [8:0] r;
        r = {1'b0, 8'h00};
        if (idx == IW'(`DACDP_IDX_DIN))
            r = {1'b0, 5'h00, cfg_q.din_mode, din_level};
        else if (idx == IW'(`DACDP_IDX_BLK))
            r = {1'b0, 3'h0, cfg_q.block_sel};
        else if (idx == IW'(`DACDP_IDX_SETUP))
            r = {1'b0, cfg_q.left_power, cfg_q.right_power, cfg_q.left_src, cfg_q.right_src,
                 cfg_q.soft_step};
        else if (idx == IW'(`DACDP_IDX_VOL))
            r = {1'b0, 4'h0, cfg_q.left_mute, cfg_q.right_mute, cfg_q.coupling};
        else if (idx == IW'(`DACDP_IDX_RSVD_A))
            r = {1'b0, 8'h00};
        else if (idx >= IW'(`DACDP_IDX_RSVD_B_LO) && idx <= IW'(`DACDP_IDX_RSVD_C_HI))
            r = {1'b0, 8'h00};
        else
            r = {1'b1, 8'h00};
        return r;
    endfunction : rd_word

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshake state

    logic aw_hold_q, aw_hold_d;
    logic w_hold_q, w_hold_d;
    logic [IW-1:0] widx_q, widx_d;
    logic [7:0] wbyte_q, wbyte_d;
    logic wlane_q, wlane_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [7:0] rbyte_q, rbyte_d;
    logic wr_fire;
    logic [8:0] rd_res;
    logic [8:0] wr_chk;

    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    always_comb rd_res = rd_word(s_axi_araddr_i[ADDR_W-1:2]);
    always_comb wr_chk = rd_word(widx_q);

    always_comb
    begin
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        widx_d = widx_q;
        wbyte_d = wbyte_q;
        wlane_d = wlane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rbyte_d = rbyte_q;
        if (s_axi_awvalid_i && !aw_hold_q)
        begin
            aw_hold_d = 1'b1;
            widx_d = s_axi_awaddr_i[ADDR_W-1:2];
        end
        if (s_axi_wvalid_i && !w_hold_q)
        begin
            w_hold_d = 1'b1;
            wbyte_d = s_axi_wdata_i[7:0];
            wlane_d = s_axi_wstrb_i[0];
        end
        if (wr_fire)
        begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_chk[8] ? `DACDP_RESP_DECERR : `DACDP_RESP_OKAY;
        end
        else if (bvalid_q && s_axi_bready_i)
            bvalid_d = 1'b0;
        if (s_axi_arvalid_i && !rvalid_q)
        begin
            rvalid_d = 1'b1;
            rbyte_d = rd_res[7:0];
            rresp_d = rd_res[8] ? `DACDP_RESP_DECERR : `DACDP_RESP_OKAY;
        end
        else if (rvalid_q && s_axi_rready_i)
            rvalid_d = 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            widx_q <= '0;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `DACDP_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= `DACDP_RESP_OKAY;
            rbyte_q <= 8'h00;
        end
        else
        begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            widx_q <= widx_d;
            wbyte_q <= wbyte_d;
            wlane_q <= wlane_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rbyte_q <= rbyte_d;
        end
    end

    assign s_axi_awready_o = !aw_hold_q;
    assign s_axi_wready_o = !w_hold_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = !rvalid_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rresp_o = rresp_q;
    assign s_axi_rdata_o = {24'h0000_00, rbyte_q};

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic wr_en;

    assign wr_en = wr_fire && wlane_q;

    always_comb
    begin
        cfg_d = cfg_q;
        if (wr_en && widx_q == IW'(`DACDP_IDX_DIN))
        begin
            if (wbyte_q[2:1] != 2'(DACDP_PIN_RSVD))
                cfg_d.din_mode = dacdp_pin_mode_t'(wbyte_q[2:1]);
        end
        else if (wr_en && widx_q == IW'(`DACDP_IDX_BLK))
        begin
            if (wbyte_q[4:0] >= `DACDP_BLK_FIRST && wbyte_q[4:0] <= `DACDP_BLK_LAST)
                cfg_d.block_sel = wbyte_q[4:0];
        end
        else if (wr_en && widx_q == IW'(`DACDP_IDX_SETUP))
        begin
            cfg_d.left_power = wbyte_q[`DACDP_SETUP_LPWR];
            cfg_d.right_power = wbyte_q[`DACDP_SETUP_RPWR];
            cfg_d.left_src = dacdp_src_t'(wbyte_q[`DACDP_SETUP_LSRC_LSB +: 2]);
            cfg_d.right_src = dacdp_src_t'(wbyte_q[`DACDP_SETUP_RSRC_LSB +: 2]);
            if (wbyte_q[`DACDP_SETUP_STEP_LSB +: 2] != 2'(DACDP_STEP_RSVD))
                cfg_d.soft_step = dacdp_step_t'(wbyte_q[`DACDP_SETUP_STEP_LSB +: 2]);
        end
        else if (wr_en && widx_q == IW'(`DACDP_IDX_VOL))
        begin
            cfg_d.left_mute = wbyte_q[`DACDP_VOL_LMUTE];
            cfg_d.right_mute = wbyte_q[`DACDP_VOL_RMUTE];
            cfg_d.coupling = dacdp_cpl_t'(wbyte_q[`DACDP_VOL_CPL_LSB +: 2]);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            cfg_q.din_mode <= dacdp_pin_mode_t'(`DACDP_RST_DIN_MODE);
            cfg_q.block_sel <= `DACDP_RST_BLK;
            cfg_q.left_power <= 1'b0;
            cfg_q.right_power <= 1'b0;
            cfg_q.left_src <= dacdp_src_t'(`DACDP_RST_SRC);
            cfg_q.right_src <= dacdp_src_t'(`DACDP_RST_SRC);
            cfg_q.soft_step <= dacdp_step_t'(`DACDP_RST_STEP);
            cfg_q.left_mute <= `DACDP_RST_MUTE;
            cfg_q.right_mute <= `DACDP_RST_MUTE;
            cfg_q.coupling <= dacdp_cpl_t'(`DACDP_RST_CPL);
        end
        else
            cfg_q <= cfg_d;
    end

    assign cfg_o = cfg_q;
    assign din_serial_en_o = (cfg_q.din_mode == DACDP_PIN_SERIAL);
    assign din_gpi_o = (cfg_q.din_mode == DACDP_PIN_GPI) && din_sync;

    ////////////////////////////////////////////////////////////////////////////////
    // Volume coupling

    logic [VOL_W-1:0] lvol_q, lvol_d;
    logic [VOL_W-1:0] rvol_q, rvol_d;

    always_comb
    begin
        lvol_d = left_vol_i;
        rvol_d = right_vol_i;
        if (!drc_enable_i && cfg_q.coupling == DACDP_CPL_L_FROM_R)
            lvol_d = right_vol_i;
        else if (!drc_enable_i && cfg_q.coupling == DACDP_CPL_R_FROM_L)
            rvol_d = left_vol_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            lvol_q <= '0;
            rvol_q <= '0;
        end
        else
        begin
            lvol_q <= lvol_d;
            rvol_q <= rvol_d;
        end
    end

    assign left_vol_o = lvol_q;
    assign right_vol_o = rvol_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Channel routing

    dacdp_mix #(.SAMPLE_W(SAMPLE_W)) u_left (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .valid_i(sample_valid_i),
        .own_i(left_i),
        .other_i(right_i),
        .src_i(cfg_q.left_src),
        .pass_i(cfg_q.left_power && !cfg_q.left_mute),
        .valid_o(left_valid_o),
        .sample_o(left_o)
    );

    dacdp_mix #(.SAMPLE_W(SAMPLE_W)) u_right (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .valid_i(sample_valid_i),
        .own_i(right_i),
        .other_i(left_i),
        .src_i(cfg_q.right_src),
        .pass_i(cfg_q.right_power && !cfg_q.right_mute),
        .valid_o(right_valid_o),
        .sample_o(right_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    property p_din_rst;
        $past(!nrst_i) |-> cfg_q.din_mode == DACDP_PIN_SERIAL && cfg_q.block_sel == 5'h01;
    endproperty
    a_din_rst: assert property (p_din_rst) else $error("reset modes wrong");

    property p_din_read;
        s_axi_arvalid_i && !rvalid_q && s_axi_araddr_i[ADDR_W-1:2] == IW'(`DACDP_IDX_DIN)
        |=> s_axi_rdata_o[2:0] == {$past(cfg_q.din_mode), $past(din_level)};
    endproperty
    a_din_read: assert property (p_din_read) else $error("pin register read wrong");

    property p_blk_range;
        cfg_q.block_sel >= 5'h01 && cfg_q.block_sel <= 5'h19;
    endproperty
    a_blk_range: assert property (p_blk_range) else $error("block select out of range");

    property p_pwr;
        wr_en && widx_q == IW'(`DACDP_IDX_SETUP)
        |=> cfg_q.left_power == $past(wbyte_q[7]) && cfg_q.right_power == $past(wbyte_q[6]);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power bits not written");

    property p_src;
        wr_en && widx_q == IW'(`DACDP_IDX_SETUP)
        |=> cfg_q.left_src == $past(wbyte_q[5:4]) && cfg_q.right_src == $past(wbyte_q[3:2]);
    endproperty
    a_src: assert property (p_src) else $error("source fields not written");

    property p_step;
        cfg_q.soft_step != DACDP_STEP_RSVD;
    endproperty
    a_step: assert property (p_step) else $error("soft-step holds reserved code");

    property p_mute;
        sample_valid_i && cfg_q.left_mute
        |=> left_o == '0;
    endproperty
    a_mute: assert property (p_mute) else $error("muted left not silent");

    property p_rmute;
        $past(!nrst_i) |-> cfg_q.right_mute && cfg_q.left_mute;
    endproperty
    a_rmute: assert property (p_rmute) else $error("channels not muted at reset");

    property p_cpl;
        !drc_enable_i && cfg_q.coupling == DACDP_CPL_L_FROM_R |=> left_vol_o == $past(right_vol_i);
    endproperty
    a_cpl: assert property (p_cpl) else $error("left gain not coupled");

    property p_drc;
        drc_enable_i |=> left_vol_o == $past(left_vol_i) && right_vol_o == $past(right_vol_i);
    endproperty
    a_drc: assert property (p_drc) else $error("coupling active under compressor");

    c_write: cover property (wr_fire ##[1:4] s_axi_bvalid_o && s_axi_bready_i);
    c_avg: cover property (sample_valid_i && cfg_q.left_src == DACDP_SRC_AVG && cfg_q.left_power);
    c_cpl: cover property (!drc_enable_i && cfg_q.coupling == DACDP_CPL_R_FROM_L);
endmodule : dacdp_regs
`default_nettype wire

/* sim/test_dacdp_regs.sv */
// Self-checking bench for the playback path configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "dacdp_defs.svh"
module test_dacdp_regs;
logic clk_i = 0, nrst_i = 0, awv = 0, wv = 0, arv = 0, sv = 0, pin = 0, dynamic_range_compressor = 0;
logic [9:0] awaddr = 0, araddr = 0;
logic [31:0] wdata = 0, rdata;
logic [7:0] lv = 8'h10, rv = 8'h20, lvo, rvo;
logic signed [23:0] li = 0, ri = 0, lo, ro;
logic awr, wr, bv, arr, rvld, general_purpose_input, lvv, ser, rvv;
dacdp_pkg::dacdp_cfg_t cfg;
logic [1:0] bresp, rresp;
int n_fail = 0, cmp_count = 0;
always #25 clk_i = ~clk_i;
dacdp_regs uut (.clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvld), .s_axi_rready_i(1'b1), .din_pin_i(pin),
    .din_serial_en_o(ser), .din_gpi_o(general_purpose_input), .drc_enable_i(dynamic_range_compressor), .left_vol_i(lv), .right_vol_i(rv),
    .left_vol_o(lvo), .right_vol_o(rvo), .cfg_o(cfg), .sample_valid_i(sv), .left_i(li),
    .right_i(ri), .left_valid_o(lvv), .left_o(lo), .right_valid_o(rvv), .right_o(ro));
////////////////////////////////////////////////////////////////////////////////
task automatic conclude;
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask : conclude
task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
        n_fail++;
        $display("mismatch %s expected %h seen %h", n, e, g);
    end
endtask : chk
// AXI4-Lite write, address and data offered together
task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw;
    int k;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    ta = 0;
    tw = 0;
    k = 0;
    while (!(ta && tw) && k < 40)
    begin
        @(negedge clk_i);
        ta = ta || awr;
        tw = tw || wr;
        @(posedge clk_i);
        if (ta) awv <= 1'b0;
        if (tw) wv <= 1'b0;
        k++;
    end
    do
    begin
        @(negedge clk_i);
        k++;
    end while (bv !== 1'b1 && k < 80);
    chk("bvalid", 32'h1, 32'(bv));
    chk("bresp", 32'(er), 32'(bresp));
    @(posedge clk_i);
endtask : wr_reg
task automatic rd_reg(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
    int k;
    araddr <= {idx, 2'b00};
    arv <= 1'b1;
    k = 0;
    do
    begin
        @(negedge clk_i);
        k++;
    end while (arr !== 1'b1 && k < 40);
    @(posedge clk_i);
    arv <= 1'b0;
    do
    begin
        @(negedge clk_i);
        k++;
    end while (rvld !== 1'b1 && k < 80);
    chk("rvalid", 32'h1, 32'(rvld));
    chk("rdata", {24'h0, e}, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    @(posedge clk_i);
endtask : rd_reg
task automatic smp(input logic [23:0] l, input logic [23:0] r, input logic [23:0] el,
    input logic [23:0] er);
    li <= l;
    ri <= r;
    sv <= 1'b1;
    @(posedge clk_i);
    sv <= 1'b0;
    @(negedge clk_i);
    chk("left_valid", 32'h1, 32'(lvv));
    chk("right_valid", 32'h1, 32'(rvv));
    chk("left", 32'(el), {8'h00, lo});
    chk("right", 32'(er), {8'h00, ro});
    @(posedge clk_i);
endtask : smp
task automatic vol(input logic [1:0] c, input logic d, input logic [7:0] el, input logic [7:0] er);
    wr_reg(`DACDP_IDX_VOL, {6'h0, c}, 2'h0);
    dynamic_range_compressor <= d;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("left_vol", 32'(el), 32'(lvo));
    chk("right_vol", 32'(er), 32'(rvo));
    chk("coupling", 32'(c), 32'(cfg.coupling));
    @(posedge clk_i);
endtask : vol
////////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    conclude();
end
initial
begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    chk("serial_en", 32'h1, 32'(ser));
    rd_reg(`DACDP_IDX_DIN, 8'h02, 2'h0);
    rd_reg(`DACDP_IDX_BLK, 8'h01, 2'h0);
    rd_reg(`DACDP_IDX_SETUP, 8'h14, 2'h0);
    rd_reg(`DACDP_IDX_VOL, 8'h0c, 2'h0);
    // Block selector boundaries and refused codes
    wr_reg(`DACDP_IDX_BLK, 8'h19, 2'h0);
    rd_reg(`DACDP_IDX_BLK, 8'h19, 2'h0);
    wr_reg(`DACDP_IDX_BLK, 8'h1a, 2'h0);
    wr_reg(`DACDP_IDX_BLK, 8'h00, 2'h0);
    rd_reg(`DACDP_IDX_BLK, 8'h19, 2'h0);
    // Soft-step codes 01 and 10; software never writes 11
    wr_reg(`DACDP_IDX_SETUP, 8'h95, 2'h0);
    rd_reg(`DACDP_IDX_SETUP, 8'h95, 2'h0);
    wr_reg(`DACDP_IDX_SETUP, 8'h56, 2'h0);
    rd_reg(`DACDP_IDX_SETUP, 8'h56, 2'h0);
    chk("soft_step", 32'h2, 32'(cfg.soft_step));
    // Routing: average, swapped, muted, powered down
    wr_reg(`DACDP_IDX_VOL, 8'h00, 2'h0);
    wr_reg(`DACDP_IDX_SETUP, 8'hfc, 2'h0);
    smp(24'h000003, 24'hfffffa, 24'hfffffe, 24'hfffffe);
    wr_reg(`DACDP_IDX_SETUP, 8'he8, 2'h0);
    smp(24'h000003, 24'hfffffa, 24'hfffffa, 24'h000003);
    wr_reg(`DACDP_IDX_VOL, 8'h08, 2'h0);
    smp(24'h000005, 24'h000007, 24'h000000, 24'h000005);
    wr_reg(`DACDP_IDX_VOL, 8'h04, 2'h0);
    wr_reg(`DACDP_IDX_SETUP, 8'h94, 2'h0);
    smp(24'h000005, 24'h000007, 24'h000005, 24'h000000);
    wr_reg(`DACDP_IDX_SETUP, 8'h54, 2'h0);
    wr_reg(`DACDP_IDX_VOL, 8'h00, 2'h0);
    smp(24'h000005, 24'h000007, 24'h000000, 24'h000007);
    // Volume coupling, then compressor override
    vol(2'h0, 1'b0, 8'h10, 8'h20);
    vol(2'h1, 1'b0, 8'h20, 8'h20);
    vol(2'h2, 1'b0, 8'h10, 8'h10);
    vol(2'h3, 1'b0, 8'h10, 8'h20);
    vol(2'h2, 1'b1, 8'h10, 8'h20);
    // Data pin as general input, reserved mode refused
    wr_reg(`DACDP_IDX_DIN, 8'h04, 2'h0);
    pin <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("din_gpi", 32'h1, 32'(general_purpose_input));
    chk("serial_en", 32'h0, 32'(ser));
    wr_reg(`DACDP_IDX_DIN, 8'h06, 2'h0);
    rd_reg(`DACDP_IDX_DIN, 8'h05, 2'h0);
    // Reserved and unmapped places
    wr_reg(`DACDP_IDX_RSVD_A, 8'h5a, 2'h0);
    rd_reg(`DACDP_IDX_RSVD_A, 8'h00, 2'h0);
    rd_reg(8'h38, 8'h00, 2'h0);
    wr_reg(8'h41, 8'h5a, 2'h3);
    rd_reg(8'h41, 8'h00, 2'h3);
    conclude();
end
endmodule : test_dacdp_regs
`default_nettype wire
